// ==== logic/fce_host.sv ====
/*
 * fce_host: host-side controller for a byte-wide command-port flash.
 * Software issues operations over AXI4-Lite; the block writes command
 * sequences, polls status and reports the result. Assumes the flash
 * pins are wired directly, data pin through an external tri-state.
 */
`timescale 1ns/100ps
`default_nettype none
module fce_host
  import fce_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [16:0] flash_addr, // flash address
  output logic flash_ce_n, // chip select
  output logic flash_oe_n, // read strobe
  output logic flash_we_n, // write strobe
  output logic [7:0] flash_dq_o, // flash data out
  output logic flash_dq_oe, // flash data drive enable
  input wire logic [7:0] flash_dq_i, // flash data in
  output logic powerdown_reset_n // flash deep power-down, active low
);
  typedef enum logic [3:0] {
    S_PWRDN = 4'h0,
    S_IDLE = 4'h1,
    S_CMD1 = 4'h2,
    S_CMD2 = 4'h3,
    S_POLL = 4'h4,
    S_DONE = 4'h5,
    S_RD = 4'h6
  } fce_st_t;

  fce_cyc_if cyc ();
  fce_st_t state_q;
  logic [16:0] addr_q;
  logic [7:0] wdata_q, data_q, status_q;
  logic [3:0] op_q;
  logic busy_q, refused_q, suspended_q, wstrb0_q;
  logic [3:0] pd_cnt_q;
  logic go;
  logic aw_done_q, w_done_q;
  logic [31:0] aw_wd_q;
  logic [3:0] aw_addr_q;

  fce_bus_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .cyc(cyc),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );

  // legal operation check, also used for state entry
  function automatic logic op_legal(input logic [3:0] op, input logic susp);
    case (op)
      OP_READ_ARRAY, OP_READ_STATUS, OP_READ, OP_RESUME: op_legal = 1'b1;
      OP_READ_ID, OP_CLEAR_STATUS, OP_ERASE, OP_PROGRAM, OP_SUSPEND:
        op_legal = !susp;
      default: op_legal = 1'b0;
    endcase
  endfunction
  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_done_q && !s_axi_bvalid;
  assign s_axi_wready = !w_done_q && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;
  assign go = aw_done_q && w_done_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_done_q <= 1'b0;
      wstrb0_q <= 1'b0;
      w_done_q <= 1'b0;
      aw_addr_q <= 4'h0;
      aw_wd_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done_q <= 1'b1;
        aw_wd_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0]; // strobe belongs to the data beat, not to go
      end
      if (go) begin
        s_axi_bvalid <= 1'b1;
        aw_done_q <= 1'b0;
        w_done_q <= 1'b0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  // writes while busy are dropped so a running sequence is never broken up,
  // which keeps the sequence pairs and the lock-out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 17'h0_0000;
      wdata_q <= 8'h00;
    end else if (go && !busy_q) begin
      if (aw_addr_q == REG_ADDR && wstrb0_q) addr_q <= aw_wd_q[16:0];
      if (aw_addr_q == REG_WDATA && wstrb0_q) wdata_q <= aw_wd_q[7:0];
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RESULT_RESET;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {24'h00_0000, refused_q, suspended_q, busy_q, 1'b0, op_q};
        REG_ADDR: s_axi_rdata <= {15'h0000, addr_q};
        REG_WDATA: s_axi_rdata <= {24'h00_0000, wdata_q};
        // status bits 5..3 passed as read, software sees each fault
        REG_RESULT: s_axi_rdata <= {16'h0000, status_q, data_q};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // power-down release
  // ------------------------------------------------------------
  // device wakes in array mode with status 80H; nothing to send
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_cnt_q <= 4'(PWRDN_CYCLES);
      powerdown_reset_n <= 1'b0;
    end else if (pd_cnt_q != 4'h0) begin
      pd_cnt_q <= pd_cnt_q - 4'h1;
    end else begin
      powerdown_reset_n <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  logic [7:0] cmd1, cmd2;
  always_comb begin
    case (op_q)
      OP_READ_ID: cmd1 = CMD_READ_ID;
      OP_READ_STATUS: cmd1 = CMD_READ_STATUS;
      OP_CLEAR_STATUS: cmd1 = CMD_CLEAR_STATUS;
      OP_ERASE: cmd1 = CMD_ERASE_SETUP; // sent whatever the supply level
      OP_SUSPEND: cmd1 = CMD_SUSPEND;
      OP_RESUME: cmd1 = CMD_CONFIRM;
      OP_PROGRAM: cmd1 = CMD_PROGRAM_SETUP;
      default: cmd1 = CMD_READ_ARRAY;
    endcase
    cmd2 = (op_q == OP_ERASE) ? CMD_CONFIRM : wdata_q;
  end
  always_comb begin
    cyc.start = 1'b0;
    cyc.is_write = 1'b1;
    cyc.addr = addr_q; // same location on both writes
    cyc.wdata = cmd1;
    case (state_q)
      S_CMD1: cyc.start = 1'b1;
      S_CMD2: begin
        cyc.start = 1'b1;
        cyc.wdata = cmd2;
      end
      S_POLL, S_RD: begin
        cyc.start = 1'b1;
        cyc.is_write = 1'b0;
      end
      default: cyc.start = 1'b0;
    endcase
  end
  logic pending_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_PWRDN;
      op_q <= 4'h0;
      busy_q <= 1'b0;
      refused_q <= 1'b0;
      suspended_q <= 1'b0;
      pending_q <= 1'b0;
      status_q <= 8'h80;
      data_q <= 8'h00;
    end else begin
      case (state_q)
        S_PWRDN: if (powerdown_reset_n) state_q <= S_IDLE;
        S_IDLE: begin
          if (go && aw_addr_q == REG_CTRL && wstrb0_q) begin
            op_q <= aw_wd_q[3:0];
            if (op_legal(aw_wd_q[3:0], suspended_q)) begin
              refused_q <= 1'b0;
              busy_q <= 1'b1;
              state_q <= (aw_wd_q[3:0] == OP_READ) ? S_RD : S_CMD1;
            end else refused_q <= 1'b1;
          end
        end
        S_CMD1: begin
          pending_q <= 1'b1;
          if (pending_q && cyc.done) begin
            pending_q <= 1'b0;
            if (op_q == OP_ERASE || op_q == OP_PROGRAM) state_q <= S_CMD2;
            else if (op_q == OP_SUSPEND || op_q == OP_RESUME) state_q <= S_POLL;
            else if (op_q == OP_READ_STATUS) state_q <= S_RD;
            else state_q <= S_DONE;
          end
        end
        S_CMD2: begin
          pending_q <= 1'b1;
          if (pending_q && cyc.done) begin
            pending_q <= 1'b0;
            state_q <= S_POLL; // device now returns status
          end
        end
        S_POLL: begin
          // every poll is a whole read cycle with strobes raised
          pending_q <= 1'b1;
          if (pending_q && cyc.done) begin
            pending_q <= 1'b0;
            status_q <= cyc.rdata;
            if (cyc.rdata[SR_READY]) begin
              suspended_q <= (op_q == OP_SUSPEND) && cyc.rdata[SR_SUSPENDED];
              state_q <= S_DONE;
            end
          end
        end
        S_RD: begin
          pending_q <= 1'b1;
          if (pending_q && cyc.done) begin
            pending_q <= 1'b0;
            data_q <= cyc.rdata;
            if (op_q == OP_READ_STATUS) status_q <= cyc.rdata;
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          busy_q <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== logic/fce_pkg.sv ====
/*
 * fce_pkg: shared constants of the flash command host controller.
 * Assumes a byte-wide command-port flash on a parallel asynchronous bus.
 */
package fce_pkg;
  // ------------------------------------------------------------
  // flash command bytes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
  // ------------------------------------------------------------
  // flash status bit positions
  // ------------------------------------------------------------
  localparam int SR_READY = 7;
  localparam int SR_SUSPENDED = 6;
  localparam int SR_ERASE_FAIL = 5;
  localparam int SR_PROGRAM_FAIL = 4;
  localparam int SR_SUPPLY_LOW = 3;
  // ------------------------------------------------------------
  // controller registers (byte offsets)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_RESULT = 4'hC;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  // ------------------------------------------------------------
  // operations written into REG_CTRL[3:0]
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ_ARRAY = 4'h0,
    OP_READ_ID = 4'h1,
    OP_READ_STATUS = 4'h2,
    OP_CLEAR_STATUS = 4'h3,
    OP_ERASE = 4'h4,
    OP_SUSPEND = 4'h5,
    OP_RESUME = 4'h6,
    OP_PROGRAM = 4'h7,
    OP_READ = 4'h8
  } fce_op_t;
  // ------------------------------------------------------------
  // bus and power-down timing in clock cycles
  // ------------------------------------------------------------
  localparam int STROBE_CYCLES = 4;
  localparam int RECOVER_CYCLES = 2;
  localparam int PWRDN_CYCLES = 8;
endpackage

// ==== logic/fce_cyc_if.sv ====
/*
 * fce_cyc_if: one flash bus cycle request and its answer between the
 * sequencer and the pin driver. Both ends run on aclk.
 */
`timescale 1ns/100ps
`default_nettype none
interface fce_cyc_if;
  logic start;
  logic is_write;
  logic [16:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output start, output is_write, output addr, output wdata,
               input done, input rdata);
  modport pins (input start, input is_write, input addr, input wdata,
                output done, output rdata);
endinterface
`default_nettype wire

// ==== logic/fce_bus_cycle.sv ====
/*
 * fce_bus_cycle: drives one flash read or write cycle on the pins.
 * Assumes the flash data pins return to it unregistered; two flip-flops here sample them.
 */
`timescale 1ns/100ps
`default_nettype none
module fce_bus_cycle
  import fce_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  fce_cyc_if.pins cyc, // cycle request
  output logic [16:0] flash_addr, // flash address
  output logic flash_ce_n, // chip select
  output logic flash_oe_n, // read strobe
  output logic flash_we_n, // write strobe
  output logic [7:0] flash_dq_o, // data out
  output logic flash_dq_oe, // data drive enable
  input wire logic [7:0] flash_dq_i // data in
);
  typedef enum logic [1:0] {
    BC_IDLE = 2'b00,
    BC_STROBE = 2'b01,
    BC_RECOVER = 2'b10
  } fce_bc_t;
  fce_bc_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] dq_s1_q, dq_s2_q;
  logic wr_q;

  always_ff @(posedge aclk) begin
    dq_s1_q <= flash_dq_i;
    dq_s2_q <= dq_s1_q;
  end

  // ------------------------------------------------------------
  // strobe sequencing
  // ------------------------------------------------------------
  // both ce and the strobe fall and rise together, so each read gives the
  // device a fresh falling edge to latch status on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= BC_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      flash_addr <= 17'h0_0000;
      flash_dq_o <= 8'h00;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      case (state_q)
        BC_IDLE: begin
          if (cyc.start) begin
            state_q <= BC_STROBE;
            cnt_q <= 4'(STROBE_CYCLES);
            wr_q <= cyc.is_write;
            flash_addr <= cyc.addr;
            flash_dq_o <= cyc.wdata;
            flash_ce_n <= 1'b0;
            flash_we_n <= !cyc.is_write;
            flash_oe_n <= cyc.is_write;
            flash_dq_oe <= cyc.is_write;
          end
        end
        BC_STROBE: begin
          if (cnt_q == 4'h0) begin
            // rising write strobe latches address and data in the device
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            if (!wr_q) cyc.rdata <= dq_s2_q;
            state_q <= BC_RECOVER;
            cnt_q <= 4'(RECOVER_CYCLES);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        BC_RECOVER: begin
          // data held one clock cycle past the strobe for hold time
          flash_dq_oe <= 1'b0;
          if (cnt_q == 4'h0) state_q <= BC_IDLE;
          else cnt_q <= cnt_q - 4'h1;
        end
        default: state_q <= BC_IDLE;
      endcase
    end
  end

  assign cyc.done = (state_q == BC_RECOVER) && (cnt_q == 4'h0);
endmodule
`default_nettype wire

// ==== sim/fce_host_props.sv ====
/*
 * fce_host_props: pin and bus checks for fce_host.
 * Assumes only the top ports of fce_host, all in the aclk domain.
 */
`timescale 1ns/100ps
`default_nettype none
module fce_host_props (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [16:0] flash_addr, // flash address
  input wire logic flash_ce_n, // chip select
  input wire logic flash_oe_n, // read strobe
  input wire logic flash_we_n, // write strobe
  input wire logic [7:0] flash_dq_o, // data out
  input wire logic flash_dq_oe, // data drive enable
  input wire logic powerdown_reset_n, // flash reset
  input wire logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready // write response ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_we_under_ce: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("write strobe without chip select");
  chk_one_strobe: assert property (!flash_we_n |-> flash_oe_n)
    else $error("read and write strobe together");
  chk_write_drives: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("write strobe without data drive");
  chk_read_released: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("read while driving data or deselected");
  chk_strobe_width: assert property ($fell(flash_ce_n) |-> (!flash_ce_n)[*5] ##1 flash_ce_n)
    else $error("chip select low time wrong");
  chk_strobes_end: assert property ($rose(flash_ce_n) |-> flash_oe_n && flash_we_n)
    else $error("strobes not released with chip select");
  chk_ce_recover: assert property ($rose(flash_ce_n) |-> flash_ce_n[*3])
    else $error("chip select recovery too short");
  chk_addr_held: assert property (!flash_ce_n && !$fell(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved inside a cycle");
  chk_data_held: assert property (!flash_we_n && !$fell(flash_we_n) |-> $stable(flash_dq_o))
    else $error("write data moved inside a cycle");
  chk_pwrdn_quiet: assert property (!powerdown_reset_n |-> flash_ce_n && flash_we_n)
    else $error("flash accessed in power-down");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
bind fce_host fce_host_props u_props (
  .aclk(aclk), .aresetn(aresetn), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe), .powerdown_reset_n(powerdown_reset_n),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready)
);
`default_nettype wire

// ==== sim/fce_flash_model.sv ====
/*
 * fce_flash_model: behavioural byte-wide command-port flash.
 * Assumes the bench resolves the shared data pins and feeds them back.
 */
`timescale 1ns/100ps
`default_nettype none
module fce_flash_model #(
  parameter int BUSY_TICKS = 40, // automaton run length, 100 ns ticks
  parameter logic [7:0] MAKER_ID = 8'h11, // arbitrary value
  parameter logic [7:0] PART_ID = 8'h22 // arbitrary value
) (
  input wire logic powerdown_reset_n, // deep power-down, active low
  input wire logic ce_n, // chip select
  input wire logic oe_n, // read strobe
  input wire logic we_n, // write strobe
  input wire logic [16:0] addr, // address
  input wire logic [7:0] dq, // resolved data pins
  output logic [7:0] dq_drv, // data shown on reads
  input wire logic supply_high, // programming supply at high level
  input wire logic fail_inj // next operation ends in error
);
  logic [7:0] mem [int];
  logic [7:0] sr = 8'h80;
  logic [7:0] rd_q = 8'h00;
  logic [7:0] pd = 8'h00;
  logic [16:0] pa = 17'h0;
  logic susp = 1'b0;
  logic susp_req = 1'b0;
  int mode = 0;
  int pend = 0;
  int op = 0;
  int left = 0;
  // select and write strobe rise in one step; judge the select as it stood before
  logic ce_q = 1'b1;
  always @(ce_n) ce_q <= ce_n;
  task automatic start(input int kind);
    op = kind;
    mode = 2;
    if (!supply_high) sr[3] = 1'b1; // contents untouched
    else begin
      sr[7] = 1'b0;
      left = BUSY_TICKS;
    end
  endtask
  always @(negedge powerdown_reset_n) begin
    mode = 0;
    pend = 0;
    susp = 1'b0;
    susp_req = 1'b0;
    sr = 8'h80;
  end
  always @(posedge we_n) begin
    if (!ce_q && powerdown_reset_n) begin // any address takes a command
      if (pend == 4) begin
        pd = dq;
        pa = addr;
        pend = 0;
        start(4);
      end else if (pend == 2) begin
        pend = 0;
        pa = addr;
        if (dq == 8'hD0) start(2);
        else sr[5:4] = 2'b11;
      end else if (!sr[7]) begin
        if (dq == 8'hB0 && op == 2) susp_req = 1'b1;
      end else if (susp) begin
        if (dq == 8'hFF) mode = 0;
        else if (dq == 8'h70) mode = 2;
        else if (dq == 8'hD0) begin
          susp = 1'b0;
          sr[7:6] = 2'b00;
          mode = 2;
        end
      end else case (dq)
        8'hFF: mode = 0;
        8'h90: mode = 1;
        8'h70: mode = 2;
        8'h50: sr[5:3] = 3'b000;
        8'h20: pend = 2;
        8'h40: pend = 4;
        default: ;
      endcase
    end
  end
  // busy writes other than suspend leave the mode at status
  always #100 begin
    if (!sr[7] && !susp) begin
      if (susp_req) begin
        susp = 1'b1;
        susp_req = 1'b0;
        sr[7:6] = 2'b11;
      end else if (left > 0) left--;
      else begin
        sr[7] = 1'b1;
        if (fail_inj) sr[op == 2 ? 5 : 4] = 1'b1;
        else if (op == 2) mem.delete(); // whole array stands in for the block
        else mem[pa] = pd;
      end
    end
  end
  always @(negedge oe_n or negedge ce_n) begin
    #1; // address changes in the same step as the strobes
    if (!oe_n && !ce_n) begin // later falling edge latches status
      if (mode == 2) rd_q = sr;
      else if (mode == 1) rd_q = addr[0] ? PART_ID : MAKER_ID;
      else rd_q = mem.exists(addr) ? mem[addr] : 8'hFF;
    end
  end
  // no pull on the pins: a released bus shows the inverse
  assign dq_drv = (!oe_n && !ce_n && powerdown_reset_n) ? rd_q : ~rd_q;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
/*
 * tb: self-checking bench for fce_host against a behavioural flash.
 * Assumes a 20 MHz aclk and the register map of fce_pkg.
 */
`timescale 1ns/100ps
`default_nettype none
module tb
  import fce_pkg::*;
;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] PART = 8'hC3; // arbitrary value
  typedef struct packed {
    logic [3:0] op;
    logic [16:0] a;
    logic [7:0] d;
    logic vpp;
    logic fail;
    logic [15:0] exp;
    logic [15:0] msk;
  } fce_row_t;
  localparam fce_row_t ROWS [21] = '{
    '{OP_READ_STATUS, 17'h0, 8'h0, 1'b1, 1'b0, 16'h0080, 16'h00FF},
    '{OP_READ_ID, 17'h0, 8'h0, 1'b1, 1'b0, 16'h0000, 16'h0000},
    '{OP_READ, 17'h0, 8'h0, 1'b1, 1'b0, {8'h00, MAKER}, 16'h00FF},
    '{OP_READ, 17'h1, 8'h0, 1'b1, 1'b0, {8'h00, PART}, 16'h00FF},
    '{OP_PROGRAM, 17'h123, 8'h5A, 1'b1, 1'b0, 16'h8000, 16'hFF00},
    '{OP_READ, 17'h123, 8'h0, 1'b1, 1'b0, 16'h0080, 16'h00FF},
    '{OP_READ_ARRAY, 17'h0, 8'h0, 1'b1, 1'b0, 16'h0000, 16'h0000},
    '{OP_READ, 17'h123, 8'h0, 1'b1, 1'b0, 16'h005A, 16'h00FF},
    '{OP_ERASE, 17'h123, 8'h0, 1'b1, 1'b0, 16'h8000, 16'hFF00},
    '{OP_READ_ARRAY, 17'h0, 8'h0, 1'b1, 1'b0, 16'h0000, 16'h0000},
    '{OP_READ, 17'h123, 8'h0, 1'b1, 1'b0, 16'h00FF, 16'h00FF},
    '{OP_PROGRAM, 17'h200, 8'h00, 1'b1, 1'b1, 16'h9000, 16'hFF00},
    '{OP_ERASE, 17'h200, 8'h0, 1'b1, 1'b0, 16'h9000, 16'hFF00},
    '{OP_CLEAR_STATUS, 17'h0, 8'h0, 1'b1, 1'b0, 16'h0000, 16'h0000},
    '{OP_READ_STATUS, 17'h0, 8'h0, 1'b1, 1'b0, 16'h0080, 16'h00FF},
    '{OP_SUSPEND, 17'h0, 8'h0, 1'b1, 1'b0, 16'h8000, 16'hFF00},
    '{OP_RESUME, 17'h0, 8'h0, 1'b1, 1'b0, 16'h8000, 16'hFF00},
    '{OP_PROGRAM, 17'h300, 8'h77, 1'b1, 1'b0, 16'h8000, 16'hFF00},
    '{OP_ERASE, 17'h300, 8'h0, 1'b0, 1'b0, 16'h8800, 16'hFF00},
    '{OP_READ_ARRAY, 17'h0, 8'h0, 1'b1, 1'b0, 16'h0000, 16'h0000},
    '{OP_READ, 17'h300, 8'h0, 1'b1, 1'b0, 16'h0077, 16'h00FF}
  };
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic supply_high = 1'b1;
  logic fail_inj = 1'b0;
  logic [31:0] res;
  logic [1:0] resp_or = 2'b00;
  wire logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe, pd_n;
  wire logic [31:0] rdata;
  wire logic [1:0] bresp, rresp;
  wire logic [16:0] fa;
  wire logic [7:0] dq_o, dq_m, dq;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int ce_falls = 0;
  int n0;
  assign dq = dq_oe ? dq_o : dq_m;
  fce_host dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flash_addr(fa), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq), .powerdown_reset_n(pd_n)
  );
  fce_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) flash (
    .powerdown_reset_n(pd_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq(dq),
    .dq_drv(dq_m), .supply_high(supply_high), .fail_inj(fail_inj)
  );
  always #25 aclk = ~aclk;
  always @(negedge ce_n) ce_falls++;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      end_of_test();
    end
  end
  // ------------------------------------------------------------
  // bus tasks, entered just after a rising edge
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp_or = resp_or | bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp_or = resp_or | rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic run_op(input logic [3:0] op, input logic [16:0] a, input logic [7:0] d);
    logic [31:0] c;
    axi_wr(REG_ADDR, {15'h0, a});
    axi_wr(REG_WDATA, {24'h0, d});
    axi_wr(REG_CTRL, {28'h0, op});
    do axi_rd(REG_CTRL, c); while (c[5] !== 1'b0);
    axi_rd(REG_RESULT, res);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checks_done++;
    if ((got & msk) !== (exp & msk)) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got & msk, exp & msk);
    end
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    @(posedge aclk);
    do_reset();
    axi_rd(REG_CTRL, res);
    chk(res, 32'h0, 32'hE0);
    foreach (ROWS[i]) begin
      supply_high <= ROWS[i].vpp;
      fail_inj <= ROWS[i].fail;
      run_op(ROWS[i].op, ROWS[i].a, ROWS[i].d);
      chk(res, {16'h0, ROWS[i].exp}, {16'h0, ROWS[i].msk});
    end
    // undefined operation: refused, no flash cycle
    n0 = ce_falls;
    axi_wr(REG_CTRL, 32'h0000_000F);
    axi_rd(REG_CTRL, res);
    chk(res, 32'h80, 32'hA0);
    chk(32'(ce_falls - n0), 32'h0, 32'hFFFF_FFFF);
    // supply-low left set, then a reset in mid-run brings status back
    do_reset();
    run_op(OP_READ_STATUS, 17'h0, 8'h0);
    chk(res, 32'h80, 32'hFF);
    chk({30'h0, resp_or}, 32'h0, 32'h3);
    end_of_test();
  end
endmodule
`default_nettype wire
